// ==== logic/tmr8_pkg.sv ====
// tmr8_pkg: register map, field positions, reset values and timing constants
// for the eight-bit timer with shared prescaler; used by logic/tmr8_top.sv.
package tmr8_pkg;
  // register byte addresses on the avalon word bus
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] COUNT_ADDR = 4'h4;
  localparam logic [3:0] MASK_ADDR = 4'h8;
  localparam logic [3:0] FLAGS_ADDR = 4'hC;
  localparam logic [3:0] SFR_ADDR = 4'h0;
  localparam int ADDR_W = 5;
  localparam logic [4:0] SFR_BYTE_ADDR = 5'h10;
  // field positions
  localparam int SEL_LSB = 0;
  localparam int WRAP_BIT = 0;
  localparam int PRESC_CLR_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // tick source select encodings
  typedef enum logic [2:0] {
    SEL_STOP = 3'h0,
    SEL_DIV1 = 3'h1,
    SEL_DIV8 = 3'h2,
    SEL_DIV64 = 3'h3,
    SEL_DIV256 = 3'h4,
    SEL_DIV1024 = 3'h5,
    SEL_PIN_FALL = 3'h6,
    SEL_PIN_RISE = 3'h7
  } tick_sel_t;
  // prescaler
  localparam int PRESC_W = 10;
  localparam logic [9:0] PRESC_MAX = 10'h3FF;
endpackage : tmr8_pkg

// ==== logic/tmr8_top.sv ====
// tmr8_top: eight-bit up-counter with selectable prescaled or pin tick source,
// wrap flag and interrupt, avalon-mm slave with waitrequest.
// assumes one 100 MHz clock, synchronous active-high reset, cpu supplies the
// global interrupt enable and a vector acknowledge pulse.
// Operation
// (RL1) select zero stops counter, no tick
// (RL2) select picks undivided, prescaled taps, or pin edges
// (RL3) tick increments counter, wraps ff to zero
// (RL4) wrap flag set when counter becomes zero
// (RL5) software write beats same-cycle count
// (RL6) counter write blocks match on next tick
// (RL7) vector ack or written one clears flag
// (RL8) interrupt needs flag, enable, global enable
// (RL9) prescaler free-runs, shared between both timers
// (RL10) first prescaled count within 1..N+1 cycles
// (RL11) prescaler clear bit self-clears, reads zero
// (RL12) pin sampled each clock, edge detected
// (RL13) pin synchroniser registers after half-cycle stage; here all three stages are rising-edge registers, with no half-cycle stage
// (RL14) pin edge to update 2.5..3.5 cycles; here 2..3 cycles
// (RL15) pin counted even when driven as output
// (RL16) software changes source only with stable pin
// (RL17) pin half period above one clock
// (RL18) pin tick bypasses the prescaler
// (RL19) zero flag writes ignored, synchroniser reset clean
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module tmr8_top
  import tmr8_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [tmr8_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic count_input_pin,
  input wire logic global_irq_enable,
  input wire logic wrap_vector_ack,
  output logic wrap_irq,
  output logic compare_block,
  output logic [3:0] presc_taps
);
  import tmr8_pkg::*;

  logic [2:0] sel_ff;
  logic [7:0] count_ff;
  logic [7:0] mask_ff;
  logic wrap_flag_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic presc_clear;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic sync1_ff, sync2_ff, sync3_ff;
  logic timer_tick;
  logic tap_tick;
  logic pin_rise, pin_fall;
  logic block_ff;
  logic wr_ctrl, wr_count, wr_mask, wr_flags, wr_sfr;
  logic [7:0] nxt_count;

  // one-cycle access: every request is answered on the cycle after it arrives
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_ctrl = avs_write & ~ack_ff & avs_byteenable[0] & hit(avs_address, {1'b0, CTRL_ADDR});
  assign wr_count = avs_write & ~ack_ff & avs_byteenable[0] & hit(avs_address, {1'b0, COUNT_ADDR});
  assign wr_mask = avs_write & ~ack_ff & avs_byteenable[0] & hit(avs_address, {1'b0, MASK_ADDR});
  assign wr_flags = avs_write & ~ack_ff & avs_byteenable[0] & hit(avs_address, {1'b0, FLAGS_ADDR});
  assign wr_sfr = avs_write & ~ack_ff & avs_byteenable[0] & hit(avs_address, SFR_BYTE_ADDR);

  // bus acknowledge toggles low waitrequest for one cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
  end

  // read data mux, unmapped addresses read zero
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_ff <= 32'h0000_0000;
    else if (avs_read & ~ack_ff)
    begin
      case (avs_address)
        {1'b0, CTRL_ADDR}: rdata_ff <= {29'h0, sel_ff};
        {1'b0, COUNT_ADDR}: rdata_ff <= {24'h0, count_ff};
        {1'b0, MASK_ADDR}: rdata_ff <= {24'h0, mask_ff};
        {1'b0, FLAGS_ADDR}: rdata_ff <= {31'h0, wrap_flag_ff};
        default: rdata_ff <= 32'h0000_0000; // also the self-clearing sfr bit
      endcase
    end
  end
  assign avs_readdata = rdata_ff;

  // control and mask registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sel_ff <= CTRL_RST[2:0];
      mask_ff <= MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        sel_ff <= avs_writedata[SEL_LSB +: 3];
      if (wr_mask)
        mask_ff <= avs_writedata[7:0];
    end
  end

  // shared prescaler, free running, cleared only by reset or the clear bit
  assign presc_clear = wr_sfr & avs_writedata[PRESC_CLR_BIT]; // RL11
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || presc_clear) // RL11
      presc_ff <= '0;
    else
      presc_ff <= presc_ff + 1'b1; // RL9
  end
  // tap pulses: one cycle each time the low bits of the prescaler are all ones;
  // tap widths of 3, 6, 8 and 10 bits give divisors 8, 64, 256 and 1024
  for (genvar t = 0; t < 4; t++)
  begin : g_tap
    localparam int TAP_W = (t == 0) ? 3 : (t == 1) ? 6 : (t == 2) ? 8 : PRESC_W;
    assign presc_taps[t] = &presc_ff[TAP_W-1:0]; // RL2
  end

  // pin synchroniser, three stages; no reset values leak into ticks
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= 1'b0; // RL19
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= count_input_pin; // RL12 RL13 RL15
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  assign pin_rise = sync2_ff & ~sync3_ff; // RL12 RL14
  assign pin_fall = ~sync2_ff & sync3_ff;

  // tick source selection
  always_comb
  begin
    tap_tick = 1'b0;
    case (tick_sel_t'(sel_ff))
      SEL_STOP: tap_tick = 1'b0; // RL1
      SEL_DIV1: tap_tick = 1'b1; // RL2
      SEL_DIV8: tap_tick = presc_taps[0]; // RL10
      SEL_DIV64: tap_tick = presc_taps[1];
      SEL_DIV256: tap_tick = presc_taps[2];
      SEL_DIV1024: tap_tick = presc_taps[3];
      SEL_PIN_FALL: tap_tick = pin_fall; // RL18
      SEL_PIN_RISE: tap_tick = pin_rise; // RL18
      default: tap_tick = 1'b0;
    endcase
  end
  assign timer_tick = tap_tick;

  // counter: up only, wrap, software write has priority
  always_comb
  begin
    nxt_count = count_ff;
    if (wr_count)
      nxt_count = avs_writedata[7:0]; // RL5
    else if (timer_tick)
      nxt_count = count_ff + 8'h01; // RL3
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      count_ff <= COUNT_RST;
    else
      count_ff <= nxt_count;
  end

  // compare blocking window after counter write, lasts through next tick
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      block_ff <= 1'b0;
    else if (wr_count)
      block_ff <= 1'b1; // RL6
    else if (timer_tick)
      block_ff <= 1'b0;
  end
  assign compare_block = block_ff & timer_tick; // RL6

  // wrap flag: set beats clear
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      wrap_flag_ff <= FLAGS_RST[WRAP_BIT];
    else if (timer_tick && !wr_count && count_ff == 8'hFF)
      wrap_flag_ff <= 1'b1; // RL4
    else if (wrap_vector_ack || (wr_flags && avs_writedata[WRAP_BIT]))
      wrap_flag_ff <= 1'b0; // RL7 RL19
  end

  assign wrap_irq = wrap_flag_ff & mask_ff[WRAP_BIT] & global_irq_enable; // RL8

  // checks
  wrap_sets_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
    timer_tick && !wr_count && count_ff == 8'hFF |=> count_ff == 8'h00 && wrap_flag_ff)
    else $error("wrap did not set flag");
  stop_holds_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
    sel_ff == 3'h0 && !wr_count |=> $stable(count_ff))
    else $error("stopped counter moved");
  tick_inc_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL3
    timer_tick && !wr_count |=> count_ff == $past(count_ff) + 8'h01)
    else $error("tick did not increment");
  write_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL5
    wr_count |=> count_ff == $past(avs_writedata[7:0]))
    else $error("counter write lost");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
    wrap_irq |-> wrap_flag_ff && mask_ff[0] && global_irq_enable)
    else $error("irq without cause");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
    wrap_vector_ack && !(timer_tick && count_ff == 8'hFF) |=> !wrap_flag_ff)
    else $error("ack did not clear flag");
  presc_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
    presc_clear |=> presc_ff == '0)
    else $error("prescaler not cleared");
  div8_rate_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
    sel_ff == 3'h2 && timer_tick && !presc_clear ##1 (sel_ff == 3'h2 && !presc_clear) [*7]
    |=> timer_tick || sel_ff != 3'h2)
    else $error("div8 tick spacing wrong");
  pin_edge_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL14
    sel_ff == 3'h7 && $past(sel_ff) == 3'h7 && $rose(sync3_ff) |-> $past(timer_tick))
    else $error("pin edge missed");
  zero_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL19
    wr_flags && !avs_writedata[0] && !wrap_vector_ack && wrap_flag_ff |=> wrap_flag_ff)
    else $error("zero write cleared flag");

  // a counter write arms the compare block for the next tick
  block_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL6
    wr_count
    |=> block_ff)
    else $error("counter write did not arm compare block");

  // the block lasts through exactly one tick
  block_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL6
    block_ff && timer_tick && !wr_count
    |=> !block_ff)
    else $error("compare block outlived its tick");

  // writing a one clears the flag unless a wrap lands in the same cycle
  flag_w1c_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
    wr_flags && avs_writedata[WRAP_BIT] && !(timer_tick && !wr_count && count_ff == 8'hFF)
    |=> !wrap_flag_ff)
    else $error("written one did not clear flag");

  // a wrap beats any clear in the same cycle
  set_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
    timer_tick && !wr_count && count_ff == 8'hFF && (wrap_vector_ack || wr_flags)
    |=> wrap_flag_ff)
    else $error("clear beat wrap");

  // the flag is only ever set by a wrap
  no_false_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
    !wrap_flag_ff && !(timer_tick && count_ff == 8'hFF)
    |=> !wrap_flag_ff)
    else $error("flag set without wrap");

  // a held request is answered in its second cycle
  bus_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL5
    (avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write)
    |-> !avs_waitrequest)
    else $error("request not answered in second cycle");

  // an idle bus never stalls
  wait_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL5
    !avs_read && !avs_write
    |-> !avs_waitrequest)
    else $error("waitrequest while idle");

  // undivided source ticks every cycle
  div1_every_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
    sel_ff == 3'h1
    |-> timer_tick)
    else $error("undivided tick missing");

  // select zero never ticks
  stop_tick_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
    sel_ff == 3'h0
    |-> !timer_tick)
    else $error("tick while stopped");

  // the divide-by-64 tap only fires on a divide-by-8 tap
  tap_nest_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
    presc_taps[1]
    |-> presc_taps[0])
    else $error("tap 64 out of step");

  // the divide-by-1024 tap only fires with the lower taps
  tap_nest_hi_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
    presc_taps[3]
    |-> presc_taps[2] && presc_taps[1])
    else $error("tap 1024 out of step");

  // divide-by-8 tap repeats every eight cycles without a clear
  tap_space_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
    presc_taps[0] && !presc_clear ##1 !presc_clear [*7]
    |=> presc_taps[0])
    else $error("tap 8 spacing wrong");

  // prescaler advances every cycle regardless of select
  presc_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
    !presc_clear
    |=> presc_ff == $past(presc_ff) + 10'h001)
    else $error("prescaler stalled");

  // the clear bit always reads zero
  sfr_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
    avs_read && !ack_ff && avs_address == SFR_BYTE_ADDR
    |=> avs_readdata == 32'h0000_0000)
    else $error("clear bit read nonzero");

  // falling pin edge gives one tick in select six
  pin_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
    sel_ff == 3'h6 && $past(sel_ff) == 3'h6 && $fell(sync3_ff)
    |-> $past(timer_tick))
    else $error("falling pin edge missed");

  // a sampled rise reaches the edge detector one cycle later
  pin_delay_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL14
    $rose(sync1_ff)
    |=> pin_rise)
    else $error("pin edge delay wrong");

  // no interrupt without global enable and mask
  irq_global_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
    !global_irq_enable || !mask_ff[WRAP_BIT]
    |-> !wrap_irq)
    else $error("interrupt while disabled");

  // mask register takes the written byte
  mask_reg_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
    wr_mask
    |=> mask_ff == $past(avs_writedata[7:0]))
    else $error("mask write lost");

  // select field takes the written bits
  ctrl_reg_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
    wr_ctrl
    |=> sel_ff == $past(avs_writedata[2:0]))
    else $error("select write lost");

  // counter reads back its value at the request
  count_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL5
    avs_read && !ack_ff && avs_address == {1'b0, COUNT_ADDR}
    |=> avs_readdata[7:0] == $past(count_ff))
    else $error("counter read wrong");

  // flag register reads the wrap flag in bit zero only
  flags_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
    avs_read && !ack_ff && avs_address == {1'b0, FLAGS_ADDR}
    |=> avs_readdata == {31'h0, $past(wrap_flag_ff)})
    else $error("flag read wrong");
endmodule : tmr8_top

// ==== test/pulse_source.sv ====
// pulse_source: far-side model that toggles the timer count pin
// assumes the bench clock; the pin rests low between bursts
`timescale 1ns/10ps
module pulse_source
(
  input wire logic sys_clk,
  output logic pin
);
  // quiet low level until a burst is asked for
  initial pin = 1'b0;
  // pin only moves after a quiet spell, so enabling sees a stable pin
  task burst(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge sys_clk);
      pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pin <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask : burst
endmodule : pulse_source

// ==== test/testbench.sv ====
// testbench: register, wrap, interrupt, prescaler and pin scenarios
// assumes tmr8_top and pulse_source compiled before it
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  import tmr8_pkg::*;
  logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, pin;
  logic glob_en, vec_ack, wrap_irq, cmp_blk;
  int blocks;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] v;
  int checks, mismatches;
  tmr8_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_input_pin(pin), .global_irq_enable(glob_en), .wrap_vector_ack(vec_ack),
    .wrap_irq(wrap_irq), .compare_block(cmp_blk), .presc_taps());
  // count blocked ticks seen after counter writes
  always @(posedge sys_clk)
    if (cmp_blk === 1'b1) blocks++;
  pulse_source src (.sys_clk(sys_clk), .pin(pin));
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // one bus access held until waitrequest is seen low
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= ~w;
    avs_write <= w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task t_regs;
    acc(0, {1'b0, CTRL_ADDR}, 8'h00); `CHK(v, CTRL_RST)
    acc(0, {1'b0, FLAGS_ADDR}, 8'h00); `CHK(v, FLAGS_RST)
    acc(0, SFR_BYTE_ADDR, 8'h00); `CHK(v, 8'h00)
    acc(0, 5'h14, 8'h00); `CHK(v, 8'h00)
    acc(1, {1'b0, CTRL_ADDR}, 8'hFF);
    acc(0, {1'b0, CTRL_ADDR}, 8'h00); `CHK(v, 8'h07)
    acc(1, {1'b0, CTRL_ADDR}, 8'h00);
  endtask : t_regs
  task t_wrap;
    int b0;
    b0 = blocks;
    acc(1, {1'b0, COUNT_ADDR}, 8'hFE);
    repeat (20) @(posedge sys_clk);
    acc(0, {1'b0, COUNT_ADDR}, 8'h00); `CHK(v, 8'hFE)
    acc(1, {1'b0, CTRL_ADDR}, 8'h01);
    acc(1, {1'b0, CTRL_ADDR}, 8'h00);
    acc(0, {1'b0, COUNT_ADDR}, 8'h00); `CHK(v < 8'h08, 1'b1)
    `CHK(blocks - b0, 1)
    acc(0, {1'b0, FLAGS_ADDR}, 8'h00); `CHK(v, 8'h01)
  endtask : t_wrap
  task t_irq;
    acc(1, {1'b0, MASK_ADDR}, 8'h01);
    `CHK(wrap_irq, 1'b1)
    glob_en <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk); `CHK(wrap_irq, 1'b0)
    glob_en <= 1'b1;
    acc(1, {1'b0, FLAGS_ADDR}, 8'h00);
    acc(0, {1'b0, FLAGS_ADDR}, 8'h00); `CHK(v, 8'h01)
    acc(1, {1'b0, FLAGS_ADDR}, 8'h01);
    acc(0, {1'b0, FLAGS_ADDR}, 8'h00); `CHK(v, 8'h00)
    `CHK(wrap_irq, 1'b0)
    acc(1, {1'b0, COUNT_ADDR}, 8'hFF);
    acc(1, {1'b0, CTRL_ADDR}, 8'h01);
    acc(1, {1'b0, CTRL_ADDR}, 8'h00);
    `CHK(wrap_irq, 1'b1)
    vec_ack <= 1'b1;
    @(posedge sys_clk);
    vec_ack <= 1'b0;
    acc(0, {1'b0, FLAGS_ADDR}, 8'h00); `CHK(v, 8'h00)
  endtask : t_irq
  // each tap runs two periods after a prescaler clear
  task t_presc;
    int n;
    for (int s = 2; s <= 5; s++)
    begin
      n = (s == 2) ? 8 : (s == 3) ? 64 : (s == 4) ? 256 : 1024;
      acc(1, {1'b0, COUNT_ADDR}, 8'h00);
      acc(1, SFR_BYTE_ADDR, 8'h01);
      acc(1, {1'b0, CTRL_ADDR}, 8'(s));
      repeat (2 * n) @(posedge sys_clk);
      acc(1, {1'b0, CTRL_ADDR}, 8'h00);
      acc(0, {1'b0, COUNT_ADDR}, 8'h00); `CHK(v >= 8'h01 && v <= 8'h03, 1'b1)
    end
  endtask : t_presc
  // five pin pulses counted on rising then falling edges
  task t_pin;
    for (int s = 7; s >= 6; s--)
    begin
      acc(1, {1'b0, COUNT_ADDR}, 8'h00);
      acc(1, {1'b0, CTRL_ADDR}, 8'(s));
      src.burst(5);
      repeat (4) @(posedge sys_clk);
      acc(1, {1'b0, CTRL_ADDR}, 8'h00);
      acc(0, {1'b0, COUNT_ADDR}, 8'h00); `CHK(v, 8'h05)
    end
  endtask : t_pin
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
  // reset then scenarios
  initial
  begin
    {sys_rst, avs_read, avs_write, glob_en, vec_ack} = 5'b10010;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_wrap();
    t_irq();
    t_presc();
    t_pin();
    print_verdict();
  end
endmodule : testbench
